// ==== hw/pec_pkg.sv ====
// pec_pkg: register map, field positions, reset values and tlp codes
// assumes: one classifier per switch port, 32-bit avalon register window
package pec_pkg;
  // register byte offsets
  localparam logic [3:0] PEC_REG_CTRL = 4'h0;
  localparam logic [3:0] PEC_REG_STAT = 4'h4;
  localparam logic [3:0] PEC_REG_LOG = 4'h8;
  localparam logic [3:0] PEC_REG_CNT = 4'hc;
  // control register fields
  localparam int PEC_CTRL_SDC_BIT = 0;
  localparam int PEC_CTRL_ECRC_BIT = 1;
  localparam int PEC_CTRL_MPS_LSB = 2;
  localparam int PEC_CTRL_MAP_LSB = 8;
  // status register fields
  localparam int PEC_STAT_OVF_BIT = 0;
  // reset values
  localparam logic [2:0] PEC_MPS_RST = 3'h0;
  localparam logic [7:0] PEC_MAP_RST = 8'h01;
  // sequence number space
  localparam logic [11:0] PEC_SEQ_HALF = 12'h800;
  // tlp sizes in dwords
  localparam logic [11:0] PEC_HDR3_DW = 12'h003;
  localparam logic [11:0] PEC_HDR4_DW = 12'h004;
  localparam logic [11:0] PEC_LEN0_DW = 12'h400;
  localparam logic [11:0] PEC_MPS_BASE_DW = 12'h020;
  localparam logic [2:0] PEC_MPS_MAX = 3'h5;
  // tlp type codes
  localparam logic [4:0] PEC_TYPE_MEM = 5'h00;
  localparam logic [4:0] PEC_TYPE_MEMLK = 5'h01;
  localparam logic [4:0] PEC_TYPE_IO = 5'h02;
  localparam logic [4:0] PEC_TYPE_CFG0 = 5'h04;
  localparam logic [4:0] PEC_TYPE_CFG1 = 5'h05;
  localparam logic [4:0] PEC_TYPE_CPL = 5'h0a;
  localparam logic [4:0] PEC_TYPE_CPLLK = 5'h0b;
  localparam logic [1:0] PEC_TYPE_MSG_HI = 2'h2;
  localparam logic [2:0] PEC_MSG_ROUTE_MAX = 3'h5;
endpackage

// ==== hw/pec_port_classifier.sv ====
// pec_port_classifier: error detection and severity sorting for one switch port
// assumes: event inputs are one-cycle pulses from logic on clk_sys_i,
// and an avalon-mm master that holds each request until waitrequest drops
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: symbol, disparity, decode faults are correctable
// RULE2: framing violations are correctable
// RULE3: training protocol breach is uncorrectable
// RULE4: nullified end-bad tlp is silently dropped
// RULE5: wrong tlp lcrc is correctable
// RULE6: unexpected non-duplicate sequence number is correctable
// RULE7: dllp with bad crc is correctable
// RULE8: flow control init breach is uncorrectable
// RULE9: stray acknak sequence number is uncorrectable
// RULE10: unblocked surprise down fatal when enabled
// RULE11: poisoned tlp nonfatal if local, else correctable
// RULE12: ecrc checked only when enabled and digest
// RULE13: ecrc fail nonfatal if local, else correctable
// RULE14: unsupported request nonfatal; non-posted is correctable
// RULE15: log header for poison, ecrc, ur, unexpected
// RULE16: no requester, so no abort or timeout
// RULE17: overflow sets flag, fatal, no header log
// RULE18: no flow control protocol checking beyond the init breach
// RULE19: malformed tlp is fatal with header log
// RULE20: illegal fmt and type pair is malformed
// RULE21: payload above max payload limit is malformed
// RULE22: length field versus received payload mismatch malformed
// RULE23: digest tlp size mismatch is malformed
// RULE24: io and config request field checks
// RULE25: traffic class must map to channel zero
// RULE26: one-cycle severity pulses plus header log strobe
module pec_port_classifier
  import pec_pkg::*;
#(
  parameter int CNT_W = 8 // width of each severity counter
)(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // physical layer events
  input wire logic phy_symbol_err_i,
  input wire logic phy_disparity_err_i,
  input wire logic phy_decode_err_i,
  input wire logic phy_framing_err_i,
  input wire logic phy_training_err_i,
  // data link layer: received tlp end
  input wire logic dll_tlp_end_i,
  input wire logic dll_tlp_endbad_i,
  input wire logic [31:0] dll_lcrc_rx_i,
  input wire logic [31:0] dll_lcrc_calc_i,
  input wire logic [11:0] dll_tlp_seq_i,
  input wire logic [11:0] dll_next_rcv_seq_i,
  // data link layer: dllps, acks and link state
  input wire logic dll_dllp_end_i,
  input wire logic [15:0] dll_dllp_crc_rx_i,
  input wire logic [15:0] dll_dllp_crc_calc_i,
  input wire logic dll_acknak_i,
  input wire logic [11:0] dll_acknak_seq_i,
  input wire logic [11:0] dll_ackd_seq_i,
  input wire logic [11:0] dll_next_tx_seq_i,
  input wire logic dll_fc_init_err_i,
  input wire logic dll_surprise_down_i,
  input wire logic dll_surprise_blocked_i,
  // transaction layer: ingress tlp header and side flags
  input wire logic tlp_valid_i,
  input wire logic [1:0] tlp_fmt_i,
  input wire logic [4:0] tlp_type_i,
  input wire logic [2:0] tlp_tc_i,
  input wire logic [1:0] tlp_attr_i,
  input wire logic tlp_td_i,
  input wire logic tlp_ep_i,
  input wire logic [9:0] tlp_length_i,
  input wire logic [3:0] tlp_last_be_i,
  input wire logic [10:0] tlp_rx_dw_i,
  input wire logic tlp_ecrc_bad_i,
  input wire logic tlp_ur_i,
  input wire logic tlp_unexp_cpl_i,
  input wire logic tlp_local_i,
  input wire logic rx_overflow_i,
  // transaction layer: egress traffic class
  input wire logic egr_valid_i,
  input wire logic [2:0] egr_tc_i,
  // classified outputs
  output logic err_cor_o,
  output logic err_nonfatal_o,
  output logic err_fatal_o,
  output logic hdr_log_o,
  output logic tlp_drop_o,
  output logic tlp_accept_o
);
  // parameter check
  if (CNT_W < 1 || CNT_W > 10) begin : g_bad_cnt_w
    $error("CNT_W must lie in 1..10");
  end

  // control and status state
  logic sdc_en_reg, sdc_en_next; // surprise-down checking
  logic ecrc_en_reg, ecrc_en_next; // ecrc checking
  logic [2:0] max_payload_limit_reg, max_payload_limit_next;
  logic [7:0] traffic_class_channel_map_reg, traffic_class_channel_map_next;
  logic receiver_overflow_flag_reg, receiver_overflow_flag_next;
  logic [19:0] log_reg, log_next; // last logged header fields
  logic [CNT_W-1:0] cnt_reg [3], cnt_next [3]; // cor, nonfatal, fatal counts
  // pulse outputs
  logic cor_reg, cor_next, nf_reg, nf_next, fat_reg, fat_next;
  logic log_stb_reg, log_stb_next, drop_reg, drop_next, acc_reg, acc_next;
  // bus state
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  // decoded bus strobes
  logic wr_go;
  // checker verdicts
  logic malformed, nonposted;
  // per-layer events
  logic phy_cor, phy_unc;
  logic nullified, lcrc_bad, seq_dup, seq_bad, dllp_bad, acknak_bad, sd_fatal, dll_unc;
  logic ecrc_chk, tl_mal, tl_ecrc, tl_ep, tl_ur, tl_ucpl;
  logic tl_cor, tl_nf, tl_fat, tl_log, egr_mal;
  logic [11:0] seq_dist, ack_dist, out_dist;

  // ingress malformed checks live in their own block
  pec_tlp_check u_check (
    .fmt_i(tlp_fmt_i),
    .type_i(tlp_type_i),
    .tc_i(tlp_tc_i),
    .attr_i(tlp_attr_i),
    .td_i(tlp_td_i),
    .length_i(tlp_length_i),
    .last_be_i(tlp_last_be_i),
    .rx_dw_i(tlp_rx_dw_i),
    .mps_i(max_payload_limit_reg),
    .tc_map_i(traffic_class_channel_map_reg),
    .malformed_o(malformed),
    .nonposted_o(nonposted)
  );

  // physical layer sorting; uncorrectable faults default to fatal severity
  always_comb begin
    phy_cor = phy_symbol_err_i | phy_disparity_err_i | phy_decode_err_i; // [RULE1]
    phy_cor = phy_cor | phy_framing_err_i; // [RULE2]
    phy_unc = phy_training_err_i; // [RULE3]
  end

  // data link layer checks
  always_comb begin
    // end-bad tlp whose lcrc is not the inverted computed one: dropped without any error
    nullified = dll_tlp_end_i && dll_tlp_endbad_i && (dll_lcrc_rx_i != ~dll_lcrc_calc_i); // [RULE4]
    lcrc_bad = dll_tlp_end_i && !nullified && (dll_lcrc_rx_i != dll_lcrc_calc_i); // [RULE5]
    // duplicates sit up to half the sequence space behind the expected value
    seq_dist = dll_next_rcv_seq_i - dll_tlp_seq_i;
    seq_dup = (seq_dist != 12'h000) && (seq_dist <= PEC_SEQ_HALF);
    seq_bad = dll_tlp_end_i && !nullified && !lcrc_bad && (seq_dist != 12'h000) && !seq_dup; // [RULE6]
    dllp_bad = dll_dllp_end_i && (dll_dllp_crc_rx_i != dll_dllp_crc_calc_i); // [RULE7]
    // an ack must name ackd_seq or a tlp still waiting for its ack
    ack_dist = dll_acknak_seq_i - dll_ackd_seq_i;
    out_dist = dll_next_tx_seq_i - dll_ackd_seq_i;
    acknak_bad = dll_acknak_i && (ack_dist != 12'h000) && (ack_dist >= out_dist); // [RULE9]
    sd_fatal = dll_surprise_down_i && !dll_surprise_blocked_i && sdc_en_reg; // [RULE10]
    // flow control init breach by the partner; no later fc protocol checks exist
    dll_unc = dll_fc_init_err_i | acknak_bad; // [RULE8] [RULE18]
  end

  // transaction layer: one verdict per tlp, malformed first, then ecrc,
  // poison, ur, unexpected completion; only the first is reported
  always_comb begin
    ecrc_chk = ecrc_en_reg && tlp_td_i; // [RULE12]
    tl_mal = tlp_valid_i && malformed; // [RULE19]
    tl_ecrc = tlp_valid_i && !tl_mal && ecrc_chk && tlp_ecrc_bad_i;
    tl_ep = tlp_valid_i && !tl_mal && !tl_ecrc && tlp_ep_i;
    tl_ur = tlp_valid_i && !tl_mal && !tl_ecrc && !tl_ep && tlp_ur_i;
    tl_ucpl = tlp_valid_i && !tl_mal && !tl_ecrc && !tl_ep && !tl_ur && tlp_unexp_cpl_i;
    // advisory cases go out as correctable
    tl_nf = (tl_ecrc && tlp_local_i) || (tl_ep && tlp_local_i) || (tl_ur && !nonposted); // [RULE11] [RULE13] [RULE14]
    tl_cor = (tl_ecrc && !tlp_local_i) || (tl_ep && !tlp_local_i) || (tl_ur && nonposted) || tl_ucpl; // [RULE11] [RULE13] [RULE14]
    // egress side only checks the traffic class map; no header is held there
    egr_mal = egr_valid_i && !traffic_class_channel_map_reg[egr_tc_i]; // [RULE25]
    // the port never issues non-posted requests, so no abort or timeout source
    tl_fat = tl_mal || rx_overflow_i || egr_mal; // [RULE16] [RULE17]
    tl_log = tl_mal || tl_ecrc || tl_ep || tl_ur || tl_ucpl; // [RULE15] [RULE19]
  end

  // bus decode: one wait cycle, then the request completes
  always_comb begin
    ack_next = (avs_read_i || avs_write_i) && !ack_reg;
    avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
    wr_go = avs_write_i && ack_reg;
  end

  // next state for registers, pulses and read data
  always_comb begin
    sdc_en_next = sdc_en_reg;
    ecrc_en_next = ecrc_en_reg;
    max_payload_limit_next = max_payload_limit_reg;
    traffic_class_channel_map_next = traffic_class_channel_map_reg;
    // software writes to control
    if (wr_go && avs_address_i == PEC_REG_CTRL) begin
      if (avs_byteenable_i[0]) begin
        sdc_en_next = avs_writedata_i[PEC_CTRL_SDC_BIT];
        ecrc_en_next = avs_writedata_i[PEC_CTRL_ECRC_BIT];
        max_payload_limit_next = avs_writedata_i[PEC_CTRL_MPS_LSB +: 3];
      end
      if (avs_byteenable_i[1]) begin
        traffic_class_channel_map_next = avs_writedata_i[PEC_CTRL_MAP_LSB +: 8];
      end
    end
    // overflow flag: write one to clear, a new overflow wins over the clear
    receiver_overflow_flag_next = receiver_overflow_flag_reg;
    if (wr_go && avs_address_i == PEC_REG_STAT && avs_byteenable_i[0] && avs_writedata_i[PEC_STAT_OVF_BIT]) begin
      receiver_overflow_flag_next = 1'b0;
    end
    if (rx_overflow_i) begin
      receiver_overflow_flag_next = 1'b1; // [RULE17]
    end
    // severity pulses, one cycle after the cause
    cor_next = phy_cor || lcrc_bad || seq_bad || dllp_bad || tl_cor; // [RULE26]
    nf_next = tl_nf; // [RULE26]
    fat_next = phy_unc || dll_unc || sd_fatal || tl_fat; // [RULE26]
    log_stb_next = tl_log; // [RULE26]
    drop_next = nullified; // [RULE4]
    acc_next = dll_tlp_end_i && !nullified && !lcrc_bad && (seq_dist == 12'h000);
    // capture the header that was logged
    log_next = log_reg;
    if (tl_log) begin
      log_next = {tlp_fmt_i, tlp_type_i, tlp_tc_i, tlp_length_i};
    end
    // saturating counters, cleared by a write; a count in the same cycle wins
    for (int i = 0; i < 3; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (wr_go && avs_address_i == PEC_REG_CNT) begin
        cnt_next[i] = '0;
      end
    end
    if (cor_next && cnt_reg[0] != '1) begin
      cnt_next[0] = cnt_reg[0] + 1'b1;
    end
    if (nf_next && cnt_reg[1] != '1) begin
      cnt_next[1] = cnt_reg[1] + 1'b1;
    end
    if (fat_next && cnt_reg[2] != '1) begin
      cnt_next[2] = cnt_reg[2] + 1'b1;
    end
    // read data is prepared during the wait cycle; unmapped reads return zero
    rdata_next = rdata_reg;
    if (avs_read_i && !ack_reg) begin
      case (avs_address_i)
        PEC_REG_CTRL: rdata_next = {16'h0000, traffic_class_channel_map_reg, 3'h0,
                                    max_payload_limit_reg, ecrc_en_reg, sdc_en_reg};
        PEC_REG_STAT: rdata_next = {31'h0, receiver_overflow_flag_reg};
        PEC_REG_LOG: rdata_next = {12'h000, log_reg};
        PEC_REG_CNT: rdata_next = {2'h0, 10'(cnt_reg[2]), 10'(cnt_reg[1]), 10'(cnt_reg[0])};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // all state registers; reset gives a quiet port with surprise-down and ecrc checks off
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sdc_en_reg <= 1'b0;
      ecrc_en_reg <= 1'b0;
      max_payload_limit_reg <= PEC_MPS_RST;
      traffic_class_channel_map_reg <= PEC_MAP_RST;
      receiver_overflow_flag_reg <= 1'b0;
      log_reg <= 20'h00000;
      for (int i = 0; i < 3; i++) begin
        cnt_reg[i] <= '0;
      end
      cor_reg <= 1'b0;
      nf_reg <= 1'b0;
      fat_reg <= 1'b0;
      log_stb_reg <= 1'b0;
      drop_reg <= 1'b0;
      acc_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      sdc_en_reg <= sdc_en_next;
      ecrc_en_reg <= ecrc_en_next;
      max_payload_limit_reg <= max_payload_limit_next;
      traffic_class_channel_map_reg <= traffic_class_channel_map_next;
      receiver_overflow_flag_reg <= receiver_overflow_flag_next;
      log_reg <= log_next;
      for (int i = 0; i < 3; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
      cor_reg <= cor_next;
      nf_reg <= nf_next;
      fat_reg <= fat_next;
      log_stb_reg <= log_stb_next;
      drop_reg <= drop_next;
      acc_reg <= acc_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    err_cor_o = cor_reg;
    err_nonfatal_o = nf_reg;
    err_fatal_o = fat_reg;
    hdr_log_o = log_stb_reg;
    tlp_drop_o = drop_reg;
    tlp_accept_o = acc_reg;
    avs_readdata_o = rdata_reg;
  end

  // checks on the design's own outputs
  default clocking pec_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence ovf_cause_s;
    rx_overflow_i && !tlp_valid_i;
  endsequence
  sequence ovf_effect_s;
    err_fatal_o && receiver_overflow_flag_reg && !hdr_log_o;
  endsequence

  phy_symbol_cor_a: assert property ((phy_symbol_err_i || phy_decode_err_i) |-> ##1 err_cor_o) // [RULE1]
    else $error("symbol fault not correctable");
  framing_cor_a: assert property (phy_framing_err_i |-> ##1 err_cor_o) // [RULE2]
    else $error("framing fault not correctable");
  training_fatal_a: assert property (phy_training_err_i |-> ##1 (err_fatal_o && !err_cor_o) or ##1 err_fatal_o) // [RULE3]
    else $error("training fault not uncorrectable");
  nullify_drop_a: assert property (dll_tlp_end_i && dll_tlp_endbad_i && dll_lcrc_rx_i != ~dll_lcrc_calc_i
    |-> ##1 (tlp_drop_o && !tlp_accept_o)) // [RULE4]
    else $error("nullified tlp not dropped");
  lcrc_cor_a: assert property (lcrc_bad |-> ##1 (err_cor_o && !tlp_accept_o && !tlp_drop_o)) // [RULE5]
    else $error("bad lcrc not correctable");
  seq_cor_a: assert property (dll_tlp_end_i && dll_lcrc_rx_i == dll_lcrc_calc_i
    && dll_next_rcv_seq_i - dll_tlp_seq_i > PEC_SEQ_HALF |-> ##1 (err_cor_o && !tlp_accept_o)) // [RULE6]
    else $error("out of order sequence missed");
  dllp_cor_a: assert property (dll_dllp_end_i && dll_dllp_crc_rx_i != dll_dllp_crc_calc_i |-> ##1 err_cor_o) // [RULE7]
    else $error("bad dllp not correctable");
  fcinit_fatal_a: assert property (dll_fc_init_err_i |-> ##1 err_fatal_o) // [RULE8]
    else $error("fc init breach not uncorrectable");
  acknak_fatal_a: assert property (dll_acknak_i && dll_acknak_seq_i == dll_next_tx_seq_i
    && dll_next_tx_seq_i != dll_ackd_seq_i |-> ##1 err_fatal_o) // [RULE9]
    else $error("stray acknak not uncorrectable");
  surprise_fatal_a: assert property (dll_surprise_down_i && !dll_surprise_blocked_i && sdc_en_reg
    |-> ##1 err_fatal_o) // [RULE10]
    else $error("surprise down not fatal");
  overflow_flag_a: assert property (ovf_cause_s |-> ##1 ovf_effect_s) // [RULE17]
    else $error("overflow handling wrong");
  malformed_log_a: assert property (tlp_valid_i && malformed |-> ##1 (err_fatal_o && hdr_log_o
    && log_reg[9:0] == $past(tlp_length_i))) // [RULE19]
    else $error("malformed tlp not fatal and logged");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus request not answered in time");
endmodule
`default_nettype wire

// ==== hw/pec_tlp_check.sv ====
// pec_tlp_check: combinational malformed checks on one ingress tlp header
// assumes: fields are stable while the caller samples the verdicts
`timescale 1ns/1ps
`default_nettype none
module pec_tlp_check
  import pec_pkg::*;
(
  // header fields
  input wire logic [1:0] fmt_i,
  input wire logic [4:0] type_i,
  input wire logic [2:0] tc_i,
  input wire logic [1:0] attr_i,
  input wire logic td_i,
  input wire logic [9:0] length_i,
  input wire logic [3:0] last_be_i,
  input wire logic [10:0] rx_dw_i,
  // port settings
  input wire logic [2:0] mps_i,
  input wire logic [7:0] tc_map_i,
  // verdicts
  output logic malformed_o,
  output logic nonposted_o
);
  logic fmt_ok; // fmt and type form a legal pair
  logic [11:0] len_dw; // length field in dwords, zero means 1024
  logic [11:0] hdr_dw; // header size
  logic [11:0] ecrc_dw; // digest size
  logic [11:0] pay_dw; // payload actually received
  logic [11:0] mps_dw; // payload limit in dwords
  logic [2:0] mps_eff; // reserved encodings clamp to the largest
  logic io_cfg; // io or configuration request
  logic posted; // memory write or message
  logic bad_fmt, bad_mps, bad_len, bad_ecrc, bad_iocfg, bad_tc;

  // legal fmt values per type; messages also need a defined routing code
  always_comb begin
    case (type_i)
      PEC_TYPE_MEM: fmt_ok = 1'b1;
      PEC_TYPE_MEMLK: fmt_ok = ~fmt_i[1];
      PEC_TYPE_IO, PEC_TYPE_CFG0, PEC_TYPE_CFG1, PEC_TYPE_CPL, PEC_TYPE_CPLLK: fmt_ok = ~fmt_i[0];
      default: fmt_ok = (type_i[4:3] == PEC_TYPE_MSG_HI) && fmt_i[0] && (type_i[2:0] <= PEC_MSG_ROUTE_MAX);
    endcase
  end

  // size arithmetic; a short frame wraps pay_dw high and fails the length match
  always_comb begin
    len_dw = (length_i == 10'h000) ? PEC_LEN0_DW : {2'h0, length_i};
    hdr_dw = fmt_i[0] ? PEC_HDR4_DW : PEC_HDR3_DW;
    ecrc_dw = {11'h000, td_i};
    pay_dw = {1'b0, rx_dw_i} - hdr_dw - ecrc_dw;
    mps_eff = (mps_i > PEC_MPS_MAX) ? PEC_MPS_MAX : mps_i;
    mps_dw = PEC_MPS_BASE_DW << mps_eff;
    io_cfg = (type_i == PEC_TYPE_IO) || (type_i == PEC_TYPE_CFG0) || (type_i == PEC_TYPE_CFG1);
    posted = (type_i[4:3] == PEC_TYPE_MSG_HI) || ((type_i == PEC_TYPE_MEM) && fmt_i[1]);
  end

  // individual checks, or-ed into one verdict
  always_comb begin
    bad_fmt = ~fmt_ok; // [RULE20]
    bad_mps = fmt_i[1] && (len_dw > mps_dw); // [RULE21]
    bad_len = fmt_i[1] && (pay_dw != len_dw); // [RULE22]
    bad_ecrc = td_i && ({1'b0, rx_dw_i} != hdr_dw + (fmt_i[1] ? len_dw : 12'h000) + ecrc_dw); // [RULE23]
    bad_iocfg = io_cfg && ((len_dw != 12'h001) || (tc_i != 3'h0) || (attr_i != 2'h0) || (last_be_i != 4'h0)); // [RULE24]
    bad_tc = ~tc_map_i[tc_i]; // [RULE25]
    malformed_o = bad_fmt | bad_mps | bad_len | bad_ecrc | bad_iocfg | bad_tc;
    nonposted_o = ~posted && (type_i != PEC_TYPE_CPL) && (type_i != PEC_TYPE_CPLLK);
  end
endmodule
`default_nettype wire

// ==== sim/pcie_port_error_classifier_test.sv ====
// pcie_port_error_classifier_test: self-checking bench for pec_port_classifier
// assumes: one 25 MHz clock, event outputs one cycle after their cause
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module pcie_port_error_classifier_test;
  import pec_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, rd = 0, wr = 0, wt, fire = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 0, rdat, q, lr = 0, lc = 0;
  logic [2:0] kind = 0, tc = 0, etc = 0;
  logic [4:0] ph, typ = 0;
  logic te = 0, tb = 0, de = 0, an = 0, fci = 0, sd = 0, sb = 0, tv = 0, td = 0, ep = 0;
  logic eb = 0, ur = 0, uc = 0, loc = 0, ovf = 0, egv = 0, cor, nf, fat, lg, drp, acc;
  logic [11:0] sq = 0, nx = 0, aq = 0, ad = 0, ntx = 0;
  logic [15:0] cr = 0, cc = 0;
  logic [1:0] fmt = 0, at = 0;
  logic [3:0] lb = 0;
  logic [9:0] len = 0;
  logic [10:0] rxd = 0;
  int fails = 0, samples_checked = 0, n_cor = 0, n_nf = 0, n_fat = 0;
  integer seed = 32'h163dc127;
  pec_link_partner pec_link_partner_i (.clk_sys_i(clk_sys_i), .fire_i(fire), .kind_i(kind), .fault_o(ph));
  pec_port_classifier pec_port_classifier_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .phy_symbol_err_i(ph[0]), .phy_disparity_err_i(ph[1]), .phy_decode_err_i(ph[2]),
    .phy_framing_err_i(ph[3]), .phy_training_err_i(ph[4]), .dll_tlp_end_i(te),
    .dll_tlp_endbad_i(tb), .dll_lcrc_rx_i(lr), .dll_lcrc_calc_i(lc), .dll_tlp_seq_i(sq),
    .dll_next_rcv_seq_i(nx), .dll_dllp_end_i(de), .dll_dllp_crc_rx_i(cr), .dll_dllp_crc_calc_i(cc),
    .dll_acknak_i(an), .dll_acknak_seq_i(aq), .dll_ackd_seq_i(ad), .dll_next_tx_seq_i(ntx),
    .dll_fc_init_err_i(fci), .dll_surprise_down_i(sd), .dll_surprise_blocked_i(sb),
    .tlp_valid_i(tv), .tlp_fmt_i(fmt), .tlp_type_i(typ), .tlp_tc_i(tc), .tlp_attr_i(at),
    .tlp_td_i(td), .tlp_ep_i(ep), .tlp_length_i(len), .tlp_last_be_i(lb), .tlp_rx_dw_i(rxd),
    .tlp_ecrc_bad_i(eb), .tlp_ur_i(ur), .tlp_unexp_cpl_i(uc), .tlp_local_i(loc),
    .rx_overflow_i(ovf), .egr_valid_i(egv), .egr_tc_i(etc), .err_cor_o(cor), .err_nonfatal_o(nf),
    .err_fatal_o(fat), .hdr_log_o(lg), .tlp_drop_o(drp), .tlp_accept_o(acc));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    {rd, wr, addr, wd} <= {!w, w, a, d};
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wt !== 1'b0 && k < 100);
    if (k >= 100) fails++;
    r = rdat;
    {rd, wr} <= 2'b00;
  endtask
  // drop all pulses, then compare {cor,nf,fatal,log,drop,accept} and count severities
  task automatic ev(input logic [5:0] e);
    @(posedge clk_sys_i);
    {te, tb, de, an, fci, sd, tv, ovf, egv} <= '0;
    #1;
    `CHK({cor, nf, fat, lg, drp, acc}, e)
    n_cor += e[5];
    n_nf += e[4];
    n_fat += e[3];
  endtask
  // received tlp end with lcrc flipped by x and sequence offset from the expected one
  task automatic dtl(input logic b, input logic [31:0] x, input logic [11:0] o, input logic [5:0] e);
    logic [31:0] v;
    logic [11:0] n;
    v = $random(seed);
    n = $random(seed);
    @(posedge clk_sys_i);
    {te, tb, lr, lc, nx, sq} <= {1'b1, b, v, v ^ x, n, n + o};
    ev(e);
  endtask
  // one ingress tlp; fl = {digest, poison, ecrc bad, unsupported, unexpected cpl}
  task automatic tlp(input logic [1:0] f, input logic [4:0] t, input logic [9:0] l, input logic [10:0] r,
      input logic [4:0] fl, input logic [5:0] e);
    @(posedge clk_sys_i);
    {tv, fmt, typ, len, rxd, td, ep, eb, ur, uc} <= {1'b1, f, t, l, r, fl};
    ev(e);
  endtask
  task automatic report_and_stop;
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run is about 130 cycles; the limit leaves ample margin
  initial begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    bus(0, PEC_REG_CTRL, 0, q); `CHK(q, 32'h00000100)
    bus(0, 4'h2, 0, q); `CHK(q, 32'h00000000)
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys_i); fire <= 1'b1; kind <= k[2:0];
      @(posedge clk_sys_i); fire <= 1'b0;
      ev(k == 4 ? 6'h08 : 6'h20);
    end
    dtl(0, 0, 0, 6'h01);
    dtl(0, 32'h10, 0, 6'h20);
    dtl(1, 32'h10, 0, 6'h02);
    dtl(1, 32'hffffffff, 0, 6'h20);
    dtl(0, 0, 12'h005, 6'h20);
    dtl(0, 0, 12'hfff, 6'h00);
    @(posedge clk_sys_i); {de, cr, cc} <= {1'b1, 16'h1234, 16'h1235}; ev(6'h20);
    @(posedge clk_sys_i); {an, ad, ntx, aq} <= {1'b1, 12'd100, 12'd110, 12'd105}; ev(6'h00);
    @(posedge clk_sys_i); {an, aq} <= {1'b1, 12'd300}; ev(6'h08);
    @(posedge clk_sys_i); fci <= 1'b1; ev(6'h08);
    @(posedge clk_sys_i); sd <= 1'b1; ev(6'h00);
    bus(1, PEC_REG_CTRL, 32'h00000103, q);
    bus(0, PEC_REG_CTRL, 0, q); `CHK(q, 32'h00000103)
    @(posedge clk_sys_i); {sd, sb, loc} <= 3'b111; ev(6'h00);
    @(posedge clk_sys_i); {sd, sb} <= 2'b10; ev(6'h08);
    tlp(2, PEC_TYPE_MEM, 1, 4, 5'b01000, 6'h14);
    tlp(0, PEC_TYPE_MEM, 1, 4, 5'b10100, 6'h14);
    tlp(2, PEC_TYPE_MEM, 1, 4, 5'b00010, 6'h14);
    tlp(0, PEC_TYPE_MEM, 1, 3, 5'b00010, 6'h24);
    tlp(2, PEC_TYPE_CPL, 1, 4, 5'b00001, 6'h24);
    tlp(0, PEC_TYPE_MEM, 1, 3, 5'b00100, 6'h00);
    tlp(2, PEC_TYPE_MEM, 32, 35, 0, 6'h00);
    tlp(2, PEC_TYPE_MEM, 33, 36, 0, 6'h0c);
    bus(0, PEC_REG_LOG, 0, q); `CHK(q, {12'h0, 2'h2, PEC_TYPE_MEM, 3'h0, 10'd33})
    tlp(0, 5'h1f, 1, 3, 0, 6'h0c);
    tlp(2, PEC_TYPE_MEM, 4, 6, 0, 6'h0c);
    tlp(0, PEC_TYPE_MEM, 1, 3, 5'b10000, 6'h0c);
    tlp(0, PEC_TYPE_IO, 2, 3, 0, 6'h0c);
    tlp(0, PEC_TYPE_IO, 1, 3, 0, 6'h00);
    @(posedge clk_sys_i); at <= 2'h1;
    tlp(0, PEC_TYPE_IO, 1, 3, 0, 6'h0c);
    @(posedge clk_sys_i); {at, lb} <= {2'h0, 4'hf};
    tlp(0, PEC_TYPE_CFG0, 1, 3, 0, 6'h0c);
    @(posedge clk_sys_i); lb <= 4'h0;
    @(posedge clk_sys_i); {tc, loc} <= {3'h1, 1'b0};
    tlp(0, PEC_TYPE_MEM, 1, 3, 0, 6'h0c);
    @(posedge clk_sys_i); tc <= 3'h0;
    tlp(2, PEC_TYPE_MEM, 1, 4, 5'b01000, 6'h24);
    tlp(0, PEC_TYPE_MEM, 1, 4, 5'b10100, 6'h24);
    tlp(2, PEC_TYPE_MEM, 4, 6, 5'b01000, 6'h0c);
    @(posedge clk_sys_i); {egv, etc} <= {1'b1, 3'h2}; ev(6'h08);
    @(posedge clk_sys_i); ovf <= 1'b1; ev(6'h08);
    bus(0, PEC_REG_STAT, 0, q); `CHK(q, 32'h00000001)
    bus(1, PEC_REG_STAT, 32'h00000001, q);
    bus(0, PEC_REG_STAT, 0, q); `CHK(q, 32'h00000000)
    bus(0, PEC_REG_CNT, 0, q); `CHK(q, {2'h0, n_fat[9:0], n_nf[9:0], n_cor[9:0]})
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== sim/pec_link_partner.sv ====
// pec_link_partner: far link end that commits physical faults on command
// assumes: fire_i and kind_i come from the bench on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module pec_link_partner (
  // command from the bench
  input wire logic clk_sys_i,
  input wire logic fire_i,
  input wire logic [2:0] kind_i,
  // symbol, disparity, decode, framing, training faults
  output logic [4:0] fault_o
);
  // one pulse per command; a sound link never shows a fault unasked
  always_ff @(posedge clk_sys_i) begin
    fault_o <= fire_i ? (5'h01 << kind_i) : 5'h00;
  end
endmodule
`default_nettype wire
